//--- rtl/smf_top.sv
// Serial interface with mode, frame format and clock source selection behind APB.
//
// Behaviour
// - Mode bit picks asynchronous or clocked synchronous.
// - Asynchronous character length bit picks eight or seven.
// - Parity appended only when parity enable set.
// - Stop length bit picks one or two stops.
// - Multiprocessor format replaces parity, ignores parity enable.
// - Synchronous mode: eight data bits, nothing else.
// - Asynchronous receive detects framing, parity, overrun, break.
// - Synchronous receive detects overrun only.
// - Internal baud clock; pin idle or bit-rate output.
// - External pin clock at sixteen times bit rate.
// - Synchronous internal clock always driven on pin.
// - Synchronous external clock shifts data from pin.
// - Start low, data LSB first, extra bit, stops high.
// - Receiver syncs on start edge, samples eighth tick.
// - Output clock rises at centre of each bit.
`timescale 1ns/1ns
`include "smf_params.svh"
module smf_top (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Register bus
	input wire smf_pkg::smf_apb_req_type apb_req_i,
	output smf_pkg::smf_apb_rsp_type apb_rsp_o,
	// Serial data line
	input wire logic rxd_i,
	output logic txd_o,
	// Serial clock pin
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_b_o,
	// Interrupt
	output logic irq_o
);
	import smf_pkg::*;

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	logic [7:0] mode_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] baud_reg;
	logic [8:0] tx_hold_reg;
	logic tx_pend_reg;
	logic [8:0] rx_data_reg;
	logic [`SMF_STAT_W-1:0] stat_reg;
	logic [`SMF_STAT_W-1:0] stat_next;
	logic [`SMF_STAT_W-1:0] stat_set;
	logic [`SMF_STAT_W-1:0] stat_clr;
	logic [`SMF_STAT_W-1:0] mask_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rd_mux;
	logic [7:0] baud_cnt_reg;
	logic [3:0] bit_phase_reg;
	logic sck_d_reg;
	logic rxd_d_reg;
	logic sck_s;
	logic rxd_s;
	smf_fmt_type fmt;
	smf_tx_state_type tx_state_reg;
	smf_tx_state_type tx_state_next;
	logic [7:0] tx_shift_reg;
	logic [7:0] tx_shift_next;
	logic [3:0] tx_cnt_reg;
	logic [3:0] tx_cnt_next;
	logic [1:0] tx_stop_reg;
	logic [1:0] tx_stop_next;
	logic tx_extra_reg;
	logic tx_extra_next;
	logic txd_reg;
	logic txd_next;
	logic tx_load;
	logic sck_out_reg;
	logic sck_out_next;
	smf_rx_state_type rx_state_reg;
	smf_rx_state_type rx_state_next;
	logic [7:0] rx_shift_reg;
	logic [7:0] rx_shift_next;
	logic [3:0] rx_cnt_reg;
	logic [3:0] rx_cnt_next;
	logic [3:0] rx_phase_reg;
	logic [3:0] rx_phase_next;
	logic rx_extra_reg;
	logic rx_extra_next;
	logic rx_done;
	logic [7:0] rx_word;
	logic [3:0] detect;

	// ------------------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ------------------------------------------------------------------------
	smf_sync #(
		.WIDTH(2)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.async_i({sck_i, rxd_i}),
		.sync_o({sck_s, rxd_s})
	);

	wire sck_rise = sck_s && !sck_d_reg;
	wire sck_fall = !sck_s && sck_d_reg;
	wire rxd_fall = !rxd_s && rxd_d_reg;

	// ------------------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------------------
	wire apb_setup = apb_req_i.psel && !apb_req_i.penable;
	wire apb_access = apb_req_i.psel && apb_req_i.penable;
	wire apb_wr = apb_access && apb_req_i.pwrite;
	wire [7:0] addr = apb_req_i.paddr;
	wire [31:0] wdata = apb_req_i.pwdata;
	wire hit_mode = addr == `SMF_OFS_MODE;
	wire hit_ctrl = addr == `SMF_OFS_CTRL;
	wire hit_baud = addr == `SMF_OFS_BAUD;
	wire hit_txd = addr == `SMF_OFS_TXD;
	wire hit_rxd = addr == `SMF_OFS_RXD;
	wire hit_stat = addr == `SMF_OFS_STAT;
	wire hit_mask = addr == `SMF_OFS_MASK;
	wire hit_fmt = addr == `SMF_OFS_FMT;
	wire hit_any = hit_mode || hit_ctrl || hit_baud || hit_txd || hit_rxd || hit_stat ||
		hit_mask || hit_fmt;
	wire te = ctrl_reg[`SMF_CTRL_TE];
	wire re = ctrl_reg[`SMF_CTRL_RE];

	assign fmt = smf_decode(mode_reg, ctrl_reg);
	wire extra_on = fmt.parity_on || fmt.mp_on;

	// ------------------------------------------------------------------------
	// Clock source selection
	// ------------------------------------------------------------------------
	wire int_tick = baud_cnt_reg == baud_reg;
	wire tick16 = fmt.ext_clk ? sck_rise : int_tick;
	wire phase_end = tick16 && (bit_phase_reg == `SMF_PHASE_LAST);
	wire sync_ext = fmt.sync_mode && fmt.ext_clk;
	wire tx_bit_ev = sync_ext ? sck_fall : phase_end;
	wire sync_samp = fmt.ext_clk ? sck_rise : (tick16 && bit_phase_reg == `SMF_SAMPLE_TICK);
	wire async_samp = tick16 && (rx_phase_reg == `SMF_SAMPLE_TICK);
	wire rx_samp = fmt.sync_mode ? sync_samp : async_samp;
	wire tx_busy = tx_state_reg != SMF_TX_IDLE;
	wire rx_busy = rx_state_reg != SMF_RX_IDLE;
	wire sync_run = tx_busy || re;

	// In synchronous mode clock out runs only while the synchronous side has work, so a peer never sees stray edges.
	always_comb begin
		if (fmt.sync_mode) begin
			sck_out_next = sync_run ? bit_phase_reg[3] : 1'b1;
		end else begin
			sck_out_next = bit_phase_reg[3];
		end
	end

	// ------------------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------------------
	wire tx_free = (tx_state_reg == SMF_TX_IDLE) ||
		(tx_state_reg == SMF_TX_DATA && tx_cnt_reg == 4'h0 && fmt.sync_mode) ||
		(tx_state_reg == SMF_TX_STOP && tx_stop_reg == 2'h0);

	always_comb begin
		tx_state_next = tx_state_reg;
		tx_shift_next = tx_shift_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_stop_next = tx_stop_reg;
		tx_extra_next = tx_extra_reg;
		txd_next = txd_reg;
		tx_load = 1'b0;
		if (!te) begin
			tx_state_next = SMF_TX_IDLE;
			txd_next = 1'b1;
		end else if (tx_bit_ev) begin
			case (tx_state_reg)
				SMF_TX_IDLE: begin
					txd_next = 1'b1;
				end
				SMF_TX_START, SMF_TX_DATA: begin
					if (tx_cnt_reg != 4'h0) begin
						txd_next = tx_shift_reg[0];
						tx_shift_next = {1'b0, tx_shift_reg[7:1]};
						tx_cnt_next = tx_cnt_reg - 4'h1;
						tx_state_next = SMF_TX_DATA;
					end else if (fmt.sync_mode) begin
						txd_next = 1'b1;
						tx_state_next = SMF_TX_IDLE;
					end else if (extra_on) begin
						txd_next = tx_extra_reg;
						tx_state_next = SMF_TX_EXTRA;
					end else begin
						txd_next = 1'b1;
						tx_stop_next = fmt.stop_bits - 2'h1;
						tx_state_next = SMF_TX_STOP;
					end
				end
				SMF_TX_EXTRA: begin
					txd_next = 1'b1;
					tx_stop_next = fmt.stop_bits - 2'h1;
					tx_state_next = SMF_TX_STOP;
				end
				SMF_TX_STOP: begin
					if (tx_stop_reg != 2'h0) begin
						tx_stop_next = tx_stop_reg - 2'h1;
					end else begin
						tx_state_next = SMF_TX_IDLE;
					end
				end
				default: begin
					tx_state_next = SMF_TX_IDLE;
					txd_next = 1'b1;
				end
			endcase
			if (tx_free && tx_pend_reg) begin
				tx_load = 1'b1;
				tx_extra_next = fmt.mp_on ? tx_hold_reg[8] :
					smf_parity(tx_hold_reg[7:0], fmt.data_len, fmt.parity_odd);
				if (fmt.sync_mode) begin
					txd_next = tx_hold_reg[0];
					tx_shift_next = {1'b0, tx_hold_reg[7:1]};
					tx_cnt_next = fmt.data_len - 4'h1;
					tx_state_next = SMF_TX_DATA;
				end else begin
					txd_next = 1'b0;
					tx_shift_next = tx_hold_reg[7:0];
					tx_cnt_next = fmt.data_len;
					tx_state_next = SMF_TX_START;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------------------
	always_comb begin
		rx_state_next = rx_state_reg;
		rx_shift_next = rx_shift_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_extra_next = rx_extra_reg;
		rx_phase_next = tick16 ? rx_phase_reg + 4'h1 : rx_phase_reg;
		rx_done = 1'b0;
		if (!re) begin
			rx_state_next = SMF_RX_IDLE;
		end else begin
			case (rx_state_reg)
				SMF_RX_IDLE: begin
					if (fmt.sync_mode) begin
						rx_cnt_next = fmt.data_len;
						rx_extra_next = 1'b0;
						rx_state_next = SMF_RX_DATA;
					end else if (rxd_fall) begin
						rx_phase_next = 4'h0;
						rx_state_next = SMF_RX_START;
					end
				end
				SMF_RX_START: begin
					if (rx_samp) begin
						rx_extra_next = 1'b0;
						rx_cnt_next = fmt.data_len;
						rx_state_next = rxd_s ? SMF_RX_IDLE : SMF_RX_DATA;
					end
				end
				SMF_RX_DATA: begin
					if (rx_samp) begin
						rx_shift_next = {rxd_s, rx_shift_reg[7:1]};
						rx_cnt_next = rx_cnt_reg - 4'h1;
						if (rx_cnt_reg == 4'h1) begin
							if (fmt.sync_mode) begin
								rx_done = 1'b1;
								rx_cnt_next = fmt.data_len;
							end else begin
								rx_state_next = extra_on ? SMF_RX_EXTRA : SMF_RX_STOP;
							end
						end
					end
				end
				SMF_RX_EXTRA: begin
					if (rx_samp) begin
						rx_extra_next = rxd_s;
						rx_state_next = SMF_RX_STOP;
					end
				end
				SMF_RX_STOP: begin
					if (rx_samp) begin
						rx_done = 1'b1;
						rx_state_next = SMF_RX_IDLE;
					end
				end
				default: begin
					rx_state_next = SMF_RX_IDLE;
				end
			endcase
		end
	end

	// Seven-bit characters arrive in the top bits of the shifter and need one more step down.
	assign rx_word = (fmt.data_len == `SMF_LEN_7) ? {1'b0, rx_shift_next[7:1]} : rx_shift_next;
	wire rx_store = rx_done && !stat_reg[`SMF_STAT_RXF];
	wire rx_overrun = rx_done && stat_reg[`SMF_STAT_RXF];
	wire rx_frame_err = !fmt.sync_mode && !rxd_s;
	wire rx_parity_err = fmt.parity_on &&
		(rx_extra_reg != smf_parity(rx_word, fmt.data_len, fmt.parity_odd));
	wire rx_brk = rx_frame_err && rx_word == 8'h00 && !rx_extra_reg;
	assign detect = fmt.sync_mode ? 4'h4 : 4'hf;

	// ------------------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------------------
	assign stat_set[`SMF_STAT_TXE] = tx_load;
	assign stat_set[`SMF_STAT_RXF] = rx_store;
	assign stat_set[`SMF_STAT_OVERRUN] = rx_overrun;
	assign stat_set[`SMF_STAT_FRAMING] = rx_store && rx_frame_err;
	assign stat_set[`SMF_STAT_PARITY] = rx_store && rx_parity_err;
	assign stat_set[`SMF_STAT_BRK] = rx_done && rx_brk;
	assign stat_clr = (apb_wr && hit_stat) ? wdata[`SMF_STAT_W-1:0] : {`SMF_STAT_W{1'b0}};
	// A new event in the same cycle as its clear keeps the bit set.
	assign stat_next = (stat_reg & ~stat_clr) | stat_set;

	// ------------------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------------------
	always_comb begin
		if (hit_mode) begin
			rd_mux = {24'h000000, mode_reg};
		end else if (hit_ctrl) begin
			rd_mux = {24'h000000, ctrl_reg};
		end else if (hit_baud) begin
			rd_mux = {24'h000000, baud_reg};
		end else if (hit_txd) begin
			rd_mux = {23'h000000, tx_hold_reg};
		end else if (hit_rxd) begin
			rd_mux = {23'h000000, rx_data_reg};
		end else if (hit_stat) begin
			rd_mux = {26'h0000000, stat_reg};
		end else if (hit_mask) begin
			rd_mux = {26'h0000000, mask_reg};
		end else if (hit_fmt) begin
			rd_mux = {14'h0000, detect, rx_busy, tx_busy, tx_pend_reg, fmt.sck_drive,
				fmt.ext_clk, fmt.sync_mode, fmt.stop_bits, fmt.mp_on, fmt.parity_on,
				fmt.data_len};
		end else begin
			rd_mux = 32'h00000000;
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_reg <= `SMF_MODE_RST;
			ctrl_reg <= `SMF_CTRL_RST;
			baud_reg <= `SMF_BAUD_RST;
			mask_reg <= `SMF_MASK_RST;
		end else if (apb_wr) begin
			if (hit_mode) begin
				mode_reg <= wdata[7:0];
			end else if (hit_ctrl) begin
				ctrl_reg <= wdata[7:0];
			end else if (hit_baud) begin
				baud_reg <= wdata[7:0];
			end else if (hit_mask) begin
				mask_reg <= wdata[`SMF_STAT_W-1:0];
			end
		end
	end

	// A write while a character is still pending replaces it; software polls the empty flag.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_hold_reg <= 9'h000;
			tx_pend_reg <= 1'b0;
		end else if (apb_wr && hit_txd) begin
			tx_hold_reg <= wdata[8:0];
			tx_pend_reg <= 1'b1;
		end else if (tx_load) begin
			tx_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_data_reg <= 9'h000;
			stat_reg <= {`SMF_STAT_W{1'b0}};
			prdata_reg <= 32'h00000000;
		end else begin
			if (rx_store) begin
				rx_data_reg <= {fmt.mp_on && rx_extra_reg, rx_word};
			end
			stat_reg <= stat_next;
			if (apb_setup) begin
				prdata_reg <= rd_mux;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			baud_cnt_reg <= 8'h00;
			bit_phase_reg <= 4'h0;
			sck_d_reg <= 1'b1;
			rxd_d_reg <= 1'b1;
			sck_out_reg <= 1'b1;
		end else begin
			baud_cnt_reg <= int_tick ? 8'h00 : baud_cnt_reg + 8'h01;
			bit_phase_reg <= tick16 ? bit_phase_reg + 4'h1 : bit_phase_reg;
			sck_d_reg <= sck_s;
			rxd_d_reg <= rxd_s;
			sck_out_reg <= sck_out_next;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_state_reg <= SMF_TX_IDLE;
			tx_shift_reg <= 8'h00;
			tx_cnt_reg <= 4'h0;
			tx_stop_reg <= 2'h0;
			tx_extra_reg <= 1'b0;
			txd_reg <= 1'b1;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_shift_reg <= tx_shift_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_stop_reg <= tx_stop_next;
			tx_extra_reg <= tx_extra_next;
			txd_reg <= txd_next;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_state_reg <= SMF_RX_IDLE;
			rx_shift_reg <= 8'h00;
			rx_cnt_reg <= 4'h0;
			rx_phase_reg <= 4'h0;
			rx_extra_reg <= 1'b0;
		end else begin
			rx_state_reg <= rx_state_next;
			rx_shift_reg <= rx_shift_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_phase_reg <= rx_phase_next;
			rx_extra_reg <= rx_extra_next;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign txd_o = txd_reg;
	assign sck_o = sck_out_reg;
	assign sck_oe_b_o = !fmt.sck_drive;
	assign irq_o = |(stat_reg & mask_reg);
	assign apb_rsp_o.prdata = prdata_reg;
	assign apb_rsp_o.pready = 1'b1;
	assign apb_rsp_o.pslverr = apb_access && !hit_any;

endmodule

//--- rtl/smf_params.svh
// Register offsets, field positions, reset values and timing counts of the serial block.
`ifndef SMF_PARAMS_SVH
`define SMF_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SMF_OFS_MODE 8'h00
`define SMF_OFS_CTRL 8'h04
`define SMF_OFS_BAUD 8'h08
`define SMF_OFS_TXD 8'h0c
`define SMF_OFS_RXD 8'h10
`define SMF_OFS_STAT 8'h14
`define SMF_OFS_MASK 8'h18
`define SMF_OFS_FMT 8'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SMF_MODE_SYNC 7
`define SMF_MODE_CHAR_LEN 6
`define SMF_MODE_PARITY_EN 5
`define SMF_MODE_ODD 4
`define SMF_MODE_STOP 3
`define SMF_MODE_MULTIPROC 2
`define SMF_CTRL_TE 5
`define SMF_CTRL_RE 4
`define SMF_CTRL_EXT 1
`define SMF_CTRL_CKO 0
`define SMF_STAT_TXE 0
`define SMF_STAT_RXF 1
`define SMF_STAT_OVERRUN 2
`define SMF_STAT_FRAMING 3
`define SMF_STAT_PARITY 4
`define SMF_STAT_BRK 5
`define SMF_STAT_W 6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SMF_MODE_RST 8'h00
`define SMF_CTRL_RST 8'h00
`define SMF_BAUD_RST 8'h3f
`define SMF_MASK_RST 6'h00

// ----------------------------------------------------------------------------
// Frame and timing counts
// ----------------------------------------------------------------------------
`define SMF_LEN_8 4'h8
`define SMF_LEN_7 4'h7
`define SMF_STOP_NONE 2'h0
`define SMF_STOP_ONE 2'h1
`define SMF_STOP_TWO 2'h2
`define SMF_PHASE_LAST 4'hf
`define SMF_SAMPLE_TICK 4'h7

`endif

//--- rtl/smf_pkg.sv
// Types and shared decode functions of the serial block.
`include "smf_params.svh"
package smf_pkg;

	// ------------------------------------------------------------------------
	// Bus carriers
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} smf_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} smf_apb_rsp_type;

	// ------------------------------------------------------------------------
	// Decoded frame format and state machines
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic sync_mode;
		logic [3:0] data_len;
		logic parity_on;
		logic parity_odd;
		logic mp_on;
		logic [1:0] stop_bits;
		logic ext_clk;
		logic sck_drive;
	} smf_fmt_type;

	typedef enum logic [4:0] {
		SMF_TX_IDLE = 5'h01,
		SMF_TX_START = 5'h02,
		SMF_TX_DATA = 5'h04,
		SMF_TX_EXTRA = 5'h08,
		SMF_TX_STOP = 5'h10
	} smf_tx_state_type;

	typedef enum logic [4:0] {
		SMF_RX_IDLE = 5'h01,
		SMF_RX_START = 5'h02,
		SMF_RX_DATA = 5'h04,
		SMF_RX_EXTRA = 5'h08,
		SMF_RX_STOP = 5'h10
	} smf_rx_state_type;

	// ------------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------------
	function automatic smf_fmt_type smf_decode(input logic [7:0] mode, input logic [7:0] ctrl);
		smf_fmt_type f;
		f.sync_mode = mode[`SMF_MODE_SYNC];
		f.data_len = (!mode[`SMF_MODE_SYNC] && mode[`SMF_MODE_CHAR_LEN]) ?
			`SMF_LEN_7 : `SMF_LEN_8;
		f.parity_on = !mode[`SMF_MODE_SYNC] && !mode[`SMF_MODE_MULTIPROC] &&
			mode[`SMF_MODE_PARITY_EN];
		f.parity_odd = mode[`SMF_MODE_ODD];
		f.mp_on = !mode[`SMF_MODE_SYNC] && mode[`SMF_MODE_MULTIPROC];
		f.stop_bits = mode[`SMF_MODE_SYNC] ? `SMF_STOP_NONE :
			(mode[`SMF_MODE_STOP] ? `SMF_STOP_TWO : `SMF_STOP_ONE);
		f.ext_clk = ctrl[`SMF_CTRL_EXT];
		f.sck_drive = !ctrl[`SMF_CTRL_EXT] && (mode[`SMF_MODE_SYNC] || ctrl[`SMF_CTRL_CKO]);
		return f;
	endfunction

	function automatic logic smf_parity(input logic [7:0] d, input logic [3:0] len,
		input logic odd);
		logic p;
		p = (len == `SMF_LEN_7) ? ^d[6:0] : ^d;
		return p ^ odd;
	endfunction

endpackage

//--- rtl/smf_sync.sv
// Two-flop synchroniser for pins that arrive from outside the system clock domain.
`timescale 1ns/1ns
module smf_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Pins in, synchronised levels out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// Both pins idle high, so reset to high avoids a false falling edge.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_reg <= {WIDTH{1'b1}};
			sync_reg <= {WIDTH{1'b1}};
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;

endmodule

//--- dv/smf_top_asserts.sv
// Pin and bus checks of the serial block, bound to its top module.
`timescale 1ns/1ns
`include "smf_params.svh"
module smf_top_asserts (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Watched ports
	input wire smf_pkg::smf_apb_req_type apb_req_i,
	input wire smf_pkg::smf_apb_rsp_type apb_rsp_o,
	input wire logic rxd_i,
	input wire logic txd_o,
	input wire logic sck_i,
	input wire logic sck_o,
	input wire logic sck_oe_b_o,
	input wire logic irq_o
);
	import smf_pkg::*;
	// ------------------------------------------------------------------
	// Shadow of the settings, rebuilt from the bus
	// ------------------------------------------------------------------
	logic [7:0] mode_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] baud_reg;
	logic txd_reg;
	int held_reg;
	int bit_len;
	wire wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
	wire async_on = !mode_reg[`SMF_MODE_SYNC];
	wire ext_on = ctrl_reg[`SMF_CTRL_EXT];
	wire cko_on = ctrl_reg[`SMF_CTRL_CKO];
	wire tx_on = ctrl_reg[`SMF_CTRL_TE] & async_on;
	wire unmapped = apb_req_i.paddr >= 8'h20;
	assign bit_len = 16 * (baud_reg + 1);
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_reg <= `SMF_MODE_RST;
			ctrl_reg <= `SMF_CTRL_RST;
			baud_reg <= `SMF_BAUD_RST;
			txd_reg <= 1'b1;
			held_reg <= 0;
		end else begin
			if (wr && apb_req_i.paddr == `SMF_OFS_MODE) mode_reg <= apb_req_i.pwdata[7:0];
			if (wr && apb_req_i.paddr == `SMF_OFS_CTRL) ctrl_reg <= apb_req_i.pwdata[7:0];
			if (wr && apb_req_i.paddr == `SMF_OFS_BAUD) baud_reg <= apb_req_i.pwdata[7:0];
			txd_reg <= txd_o;
			held_reg <= (txd_o != txd_reg) ? 1 : held_reg + 1;
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_setup;
		apb_req_i.psel && !apb_req_i.penable;
	endsequence
	sequence s_access;
		apb_req_i.psel && apb_req_i.penable;
	endsequence
	a_zero_wait: assert property (s_setup ##1 s_access |-> apb_rsp_o.pready)
		else $error("access phase not answered at once");
	a_err_unmapped: assert property (s_setup ##1 s_access |-> apb_rsp_o.pslverr == unmapped)
		else $error("error response does not match address");
	a_pin_unused: assert property (async_on && !ext_on && !cko_on |-> sck_oe_b_o)
		else $error("clock pin driven while unused");
	a_pin_clock_out: assert property (async_on && !ext_on && cko_on |-> !sck_oe_b_o)
		else $error("clock pin not driven for clock output");
	a_pin_sync_out: assert property (!async_on && !ext_on |-> !sck_oe_b_o)
		else $error("synchronous clock not driven");
	a_pin_ext_in: assert property (ext_on |-> sck_oe_b_o)
		else $error("clock pin driven while an input");
	a_low_whole_bits: assert property (tx_on && $rose(txd_o) |-> held_reg % bit_len == 0)
		else $error("low line time is not whole bits");
	a_clock_centre: assert property (tx_on && cko_on && !txd_o && $rose(sck_o) |->
		(held_reg % bit_len) inside {[bit_len / 2 - 1:bit_len / 2 + 1]})
		else $error("output clock rise off bit centre");
endmodule
bind smf_top smf_top_asserts u_asserts (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
	.apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .rxd_i(rxd_i), .txd_o(txd_o),
	.sck_i(sck_i), .sck_o(sck_o), .sck_oe_b_o(sck_oe_b_o), .irq_o(irq_o));

//--- dv/smf_peer.sv
// Serial peer on the far side of the line.
`timescale 1ns/1ns
module smf_peer (
	// Line towards the block
	input wire logic txd_i,
	output logic rxd_o,
	output logic sck_o
);
	// ------------------------------------------------------------------
	// Pin clock and framing
	// ------------------------------------------------------------------
	logic run = 1'b0;
	initial begin
		rxd_o = 1'b1;
		sck_o = 1'b1;
	end
	// Once started it never stops: the block loses lock if it does.
	always #80 if (run) sck_o = !sck_o;
	task automatic tx_char(input logic [11:0] v, input int n, input time bt);
		rxd_o = 1'b0;
		#bt;
		for (int i = 0; i < n; i++) begin
			rxd_o = v[i];
			#bt;
		end
		rxd_o = 1'b1;
	endtask
	task automatic rx_char(input int n, input int stops, input time bt, output logic [9:0] q);
		@(negedge txd_i);
		#(bt / 2);
		q = {txd_i, 9'h000};
		for (int i = 0; i < n; i++) begin
			#bt;
			q[i] = txd_i;
		end
		for (int i = 0; i < stops; i++) begin
			#bt;
			if (txd_i !== 1'b1) q[9] = 1'b1;
		end
	endtask
endmodule

//--- dv/smf_top_bench.sv
// Self-checking bench of the serial block.
`timescale 1ns/1ns
`include "smf_params.svh"
module smf_top_bench;
	import smf_pkg::*;
	// ------------------------------------------------------------------
	// Harness
	// ------------------------------------------------------------------
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	smf_apb_req_type req = '0;
	smf_apb_rsp_type rsp;
	logic rxd, txd, sck_in, sck_out, sck_oe_b, irq, peer_sck;
	int mismatches = 0;
	int comparisons = 0;
	always #5 clk_sys_i = !clk_sys_i;
	assign sck_in = sck_oe_b ? peer_sck : sck_out;
	smf_top u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .apb_req_i(req), .apb_rsp_o(rsp),
		.rxd_i(rxd), .txd_o(txd), .sck_i(sck_in), .sck_o(sck_out), .sck_oe_b_o(sck_oe_b),
		.irq_o(irq));
	smf_peer u_peer (.txd_i(txd), .rxd_o(rxd), .sck_o(peer_sck));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One idle cycle follows each transfer so the request never changes twice at one edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_sys_i);
		req.penable <= 1'b1;
		do @(posedge clk_sys_i); while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		req <= '0;
		@(posedge clk_sys_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rx_case(input logic [11:0] v, input time bt, input logic [31:0] msk,
		input logic [31:0] st);
		logic [31:0] q;
		// Line edges land between system clock edges, never on a sampling instant.
		@(negedge clk_sys_i);
		u_peer.tx_char(v, 10, bt);
		repeat (2) @(posedge clk_sys_i);
		apb(1'b0, `SMF_OFS_STAT, 0, q);
		chk(q & msk, st);
	endtask
	function automatic logic [31:0] fmt_exp(int m, int c);
		int s, len, par, mp, st, ext, drv;
		s = m >> 7 & 1;
		len = (!s && (m >> 6 & 1)) ? 7 : 8;
		par = !s && !(m >> 2 & 1) && (m >> 5 & 1);
		mp = !s && (m >> 2 & 1);
		st = s ? 0 : ((m >> 3 & 1) ? 2 : 1);
		ext = c >> 1 & 1;
		drv = !ext && (s || (c & 1));
		return (s ? 4 : 15) << 14 | drv << 10 | ext << 9 | s << 8 | st << 6 | mp << 5 | par << 4 | len;
	endfunction
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#500000;
		mismatches++;
		summarize();
	end
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		logic [31:0] q, e;
		logic [9:0] f;
		logic [7:0] m, d;
		void'($urandom(32'h115c));
		repeat (4) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		@(posedge clk_sys_i);
		apb(1'b0, `SMF_OFS_BAUD, 0, q);
		chk(q, 32'h3f);
		apb(1'b0, 8'h40, 0, q);
		chk(q, 0);
		for (int i = 0; i < 20; i++) begin
			m = $urandom;
			m = (i < 16) ? {1'b0, i[3], i[2], m[4], i[1], i[0], 2'b00} : m | 8'h80;
			e = fmt_exp(m, i % 4);
			wr(`SMF_OFS_MODE, m);
			wr(`SMF_OFS_CTRL, i % 4);
			apb(1'b0, `SMF_OFS_FMT, 0, q);
			chk(q & 32'h3c7ff, e);
			chk({31'b0, sck_oe_b}, {31'b0, !e[10]});
		end
		wr(`SMF_OFS_CTRL, 0);
		wr(`SMF_OFS_BAUD, 0);
		for (int k = 0; k < 2; k++) begin
			d = $urandom;
			wr(`SMF_OFS_MODE, k ? 8'h44 : 8'h28);
			wr(`SMF_OFS_CTRL, 8'h21);
			fork
				u_peer.rx_char(9 - k, 2 - k, 160, f);
				wr(`SMF_OFS_TXD, {23'b0, 1'b1, d});
			join
			chk({22'b0, f}, k ? {24'b0, 1'b1, d[6:0]} : {23'b0, ^d, d});
			wr(`SMF_OFS_CTRL, 0);
		end
		wr(`SMF_OFS_MODE, 8'h80);
		wr(`SMF_OFS_CTRL, 8'h20);
		d = $urandom;
		fork
			for (int i = 0; i < 8; i++) begin
				@(posedge sck_out) m[i] = txd;
			end
			wr(`SMF_OFS_TXD, {24'b0, d});
		join
		chk({24'b0, m}, {24'b0, d});
		wr(`SMF_OFS_CTRL, 0);
		wr(`SMF_OFS_MODE, 8'h20);
		wr(`SMF_OFS_CTRL, 8'h10);
		wr(`SMF_OFS_MASK, 2);
		d = $urandom;
		rx_case({3'b001, ^d, d}, 160, 32'h3e, 32'h02);
		apb(1'b0, `SMF_OFS_RXD, 0, q);
		chk(q, {24'b0, d});
		chk({31'b0, irq}, 1);
		wr(`SMF_OFS_MASK, 0);
		chk({31'b0, irq}, 0);
		wr(`SMF_OFS_MASK, 2);
		rx_case({3'b001, ^d, d}, 160, 32'h3e, 32'h06);
		wr(`SMF_OFS_STAT, 32'h3f);
		chk({31'b0, irq}, 0);
		rx_case({3'b001, !(^d), d}, 160, 32'h3c, 32'h10);
		wr(`SMF_OFS_STAT, 32'h3f);
		rx_case(12'h000, 160, 32'h3c, 32'h28);
		wr(`SMF_OFS_STAT, 32'h3f);
		wr(`SMF_OFS_CTRL, 8'h12);
		u_peer.run = 1'b1;
		d = $urandom;
		rx_case({3'b001, ^d, d}, 2560, 32'h3e, 32'h02);
		apb(1'b0, `SMF_OFS_RXD, 0, q);
		chk(q, {24'b0, d});
		summarize();
	end
endmodule
